// ### nvss_pkg.sv
// Package for the host-side save/restore sequencer of a byte-wide nonvolatile static memory.
// Assumes a single 250 MHz clock; all memory timing is counted in cycles of it.
`default_nettype none
package nvss_pkg;
	// Clock
	localparam int CLK_MHZ = 250;
	// Key addresses on key_address_bits (low 14 bits)
	localparam int KEY_BITS = 14;
	localparam logic [13:0] KEY_STEP1 = 14'h0E38;
	localparam logic [13:0] KEY_STEP2 = 14'h31C7;
	localparam logic [13:0] KEY_STEP3 = 14'h03E0;
	localparam logic [13:0] KEY_STEP4 = 14'h3C1F;
	localparam logic [13:0] KEY_STEP5 = 14'h303F;
	localparam logic [13:0] KEY_SAVE = 14'h0FC0;
	localparam logic [13:0] KEY_RESTORE = 14'h0C63;
	// Access timing in ns and derived cycles (least times round up)
	localparam int CYCLE_NS = 45;
	localparam int CYCLE_CLKS = (CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CLKS = 2;
	// Save, power-up restore and software restore durations
	localparam int SAVE_MS = 10;
	localparam int SAVE_CLKS = SAVE_MS * CLK_MHZ * 1000;
	localparam int PUP_RESTORE_US = 550;
	localparam int PUP_RESTORE_CLKS = PUP_RESTORE_US * CLK_MHZ;
	localparam int SW_RESTORE_US = 20;
	localparam int SW_RESTORE_CLKS = SW_RESTORE_US * CLK_MHZ;
	// Operation codes on the host command port
	typedef enum logic [1:0] {
		NVSS_OP_READ = 2'h0,
		NVSS_OP_WRITE = 2'h1,
		NVSS_OP_SAVE = 2'h2,
		NVSS_OP_RESTORE = 2'h3
	} nvss_op_t;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		NVSS_POWER = 6'b00_0001,
		NVSS_IDLE = 6'b00_0010,
		NVSS_ACCESS = 6'b00_0100,
		NVSS_GAP = 6'b00_1000,
		NVSS_BUSY = 6'b01_0000,
		NVSS_DONE = 6'b10_0000
	} nvss_state_t;
endpackage
`default_nettype wire

// ### nvss_host.sv
// Host controller that drives the memory's asynchronous strobes, issues key sequences and waits out nonvolatile cycles.
// Assumes the supply monitor flags are synchronous to ref_clk and the memory sits on its own pins.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - Memory latches a pending restore whenever supply drops below loss threshold.
// RULE2 - Memory restores itself when supply rises past trip threshold; host waits it out.
// RULE3 - Host keeps select and write strobe high when the power-up restore ends.
// RULE4 - Memory ignores saves and writes below trip threshold; host holds them back.
// RULE5 - Key starts with reads of 0E38, 31C7, 03E0; data returns normally.
// RULE6 - Fourth and fifth key reads are 3C1F then 303F, in exact order.
// RULE7 - Sixth read at 0FC0 starts a save, at 0C63 a restore.
// RULE8 - Host keeps write strobe high through all six select-controlled key cycles.
// RULE9 - Only the low 14 address bits count; host drives the top bit low.
// RULE10 - Any foreign access aborts the key; host never interleaves other accesses.
// RULE11 - Key steps are select-controlled reads; output enable may stay high.
// RULE12 - During a save the memory is off; host waits the save cycle time.
// RULE13 - Restore clears then reloads the array; host waits until it is finished.
// RULE14 - Memory matcher restarts after abort; a step-one address begins afresh.
module nvss_host
	import nvss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic nv_busy,
	output logic [14:0] mem_addr,
	output logic mem_sel_n,
	output logic mem_wr_n,
	output logic mem_oe_n,
	input wire logic [7:0] byte_lines_in,
	output logic [7:0] byte_lines_out,
	output logic byte_lines_oe
);
	// Key address for a step 0..5, the sixth chosen by the operation
	function automatic logic [13:0] key_addr(input logic [2:0] step, input logic restore);
		case (step)
			3'd0: key_addr = KEY_STEP1;
			3'd1: key_addr = KEY_STEP2;
			3'd2: key_addr = KEY_STEP3;
			3'd3: key_addr = KEY_STEP4;
			3'd4: key_addr = KEY_STEP5;
			default: key_addr = restore ? KEY_RESTORE : KEY_SAVE;
		endcase
	endfunction

	nvss_state_t state, next_state;
	logic [31:0] count, next_count;
	logic [2:0] step, next_step;
	logic in_key, next_in_key;
	logic is_restore, next_is_restore;
	logic is_read, next_is_read;
	logic next_cmd_ready, next_rsp_valid, next_nv_busy;
	logic [7:0] next_rsp_rdata;
	logic [14:0] next_mem_addr;
	logic next_mem_sel_n, next_mem_wr_n, next_mem_oe_n;
	logic [7:0] next_byte_lines_out;
	logic next_byte_lines_oe;

	// Next-state logic for the strobe sequencer
	always_comb begin
		next_state = state;
		next_count = count;
		next_step = step;
		next_in_key = in_key;
		next_is_restore = is_restore;
		next_is_read = is_read;
		next_cmd_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_nv_busy = nv_busy;
		next_mem_addr = mem_addr;
		next_mem_sel_n = mem_sel_n;
		next_mem_wr_n = mem_wr_n;
		next_mem_oe_n = mem_oe_n;
		next_byte_lines_out = byte_lines_out;
		next_byte_lines_oe = byte_lines_oe;
		case (state)
			NVSS_POWER: begin
				// Strobes idle high; memory restores itself once supply returns
				next_mem_sel_n = 1'b1; // [RULE3]
				next_mem_wr_n = 1'b1;
				next_nv_busy = 1'b1;
				if (!supply_ok) begin
					next_count = '0; // [RULE1]
				end else if (count >= 32'(PUP_RESTORE_CLKS - 1)) begin
					next_state = NVSS_IDLE; // [RULE2]
					next_nv_busy = 1'b0;
					next_cmd_ready = 1'b1;
				end else begin
					next_count = count + 32'd1;
				end
			end
			NVSS_IDLE: begin
				next_cmd_ready = 1'b1;
				if (!supply_ok) begin
					next_state = NVSS_POWER;
					next_count = '0;
					next_cmd_ready = 1'b0;
					next_nv_busy = 1'b1;
				end else if (cmd_valid) begin
					next_cmd_ready = 1'b0;
					next_count = '0;
					next_state = NVSS_ACCESS;
					next_mem_sel_n = 1'b0;
					if (cmd_op == NVSS_OP_SAVE || cmd_op == NVSS_OP_RESTORE) begin
						// Key read: write strobe and output enable high
						next_in_key = 1'b1; // [RULE11]
						next_step = 3'd0;
						next_is_restore = (cmd_op == NVSS_OP_RESTORE);
						next_is_read = 1'b1;
						next_mem_addr = {1'b0, key_addr(3'd0, cmd_op == NVSS_OP_RESTORE)}; // [RULE5] [RULE9]
						next_mem_wr_n = 1'b1; // [RULE8]
						next_mem_oe_n = 1'b1;
						next_byte_lines_oe = 1'b0;
					end else begin
						next_in_key = 1'b0;
						next_is_read = (cmd_op == NVSS_OP_READ);
						next_mem_addr = cmd_addr;
						next_mem_wr_n = (cmd_op == NVSS_OP_READ);
						next_mem_oe_n = (cmd_op != NVSS_OP_READ);
						next_byte_lines_out = cmd_wdata;
						next_byte_lines_oe = (cmd_op == NVSS_OP_WRITE);
					end
				end
			end
			NVSS_ACCESS: begin
				// Hold strobes for one access cycle, then raise select
				if (count >= 32'(CYCLE_CLKS - 1)) begin
					next_count = '0;
					next_mem_sel_n = 1'b1;
					next_mem_oe_n = 1'b1;
					next_mem_wr_n = 1'b1;
					next_byte_lines_oe = 1'b0;
					if (is_read && !in_key) begin
						next_rsp_rdata = byte_lines_in;
					end
					next_state = NVSS_GAP;
				end else begin
					next_count = count + 32'd1;
				end
			end
			NVSS_GAP: begin
				// Select high between key steps; no foreign access intervenes
				if (count >= 32'(GAP_CLKS - 1)) begin
					next_count = '0;
					if (in_key && step != 3'd5) begin
						next_step = step + 3'd1; // [RULE6] [RULE10]
						next_mem_addr = {1'b0, key_addr(step + 3'd1, is_restore)}; // [RULE7]
						next_mem_sel_n = 1'b0;
						next_state = NVSS_ACCESS;
					end else if (in_key) begin
						next_nv_busy = 1'b1; // [RULE12] [RULE13]
						next_state = NVSS_BUSY;
					end else begin
						next_state = NVSS_DONE;
					end
				end else begin
					next_count = count + 32'd1;
				end
			end
			NVSS_BUSY: begin
				// Wait out the nonvolatile cycle with strobes idle
				if (count >= 32'((is_restore ? SW_RESTORE_CLKS : SAVE_CLKS) - 1)) begin
					next_nv_busy = 1'b0;
					next_state = NVSS_DONE;
				end else begin
					next_count = count + 32'd1;
				end
			end
			NVSS_DONE: begin
				next_rsp_valid = 1'b1;
				next_in_key = 1'b0;
				next_state = NVSS_IDLE;
				next_cmd_ready = 1'b1;
			end
			default: begin
				next_state = NVSS_POWER;
				next_count = '0;
			end
		endcase
		// Below trip threshold no access may start or continue
		if (!supply_ok && state != NVSS_POWER) begin
			next_state = NVSS_POWER; // [RULE4]
			next_count = '0;
			next_mem_sel_n = 1'b1;
			next_mem_wr_n = 1'b1;
			next_mem_oe_n = 1'b1;
			next_byte_lines_oe = 1'b0;
			next_cmd_ready = 1'b0;
			next_rsp_valid = 1'b0;
			next_nv_busy = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= NVSS_POWER;
			count <= '0;
			step <= '0;
			in_key <= 1'b0;
			is_restore <= 1'b0;
			is_read <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			nv_busy <= 1'b1;
			mem_addr <= 15'h0000;
			mem_sel_n <= 1'b1;
			mem_wr_n <= 1'b1;
			mem_oe_n <= 1'b1;
			byte_lines_out <= 8'h00;
			byte_lines_oe <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			step <= next_step;
			in_key <= next_in_key;
			is_restore <= next_is_restore;
			is_read <= next_is_read;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
			nv_busy <= next_nv_busy;
			mem_addr <= next_mem_addr;
			mem_sel_n <= next_mem_sel_n;
			mem_wr_n <= next_mem_wr_n;
			mem_oe_n <= next_mem_oe_n;
			byte_lines_out <= next_byte_lines_out;
			byte_lines_oe <= next_byte_lines_oe;
		end
	end
endmodule
`default_nettype wire

// ### nvss_host_props.sv
// Pin checker for the save/restore sequencer.
// Sees only the nvss_host ports; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module nvss_host_props
	import nvss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_rdata,
	input wire logic nv_busy,
	input wire logic [14:0] mem_addr,
	input wire logic mem_sel_n,
	input wire logic mem_wr_n,
	input wire logic mem_oe_n,
	input wire logic [7:0] byte_lines_in,
	input wire logic [7:0] byte_lines_out,
	input wire logic byte_lines_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Start of one key read on the pins
	sequence key_rd(logic [13:0] a);
		$fell(mem_sel_n) && mem_oe_n && mem_wr_n && mem_addr == {1'b0, a};
	endsequence
	key_first_a: assert property (cmd_valid && cmd_ready && supply_ok && cmd_op == 2'h2 |=> key_rd(KEY_STEP1))
		else $error("key start wrong");
	key_two_a: assert property (key_rd(KEY_STEP1) |-> ##14 key_rd(KEY_STEP2)) else $error("key step two");
	key_three_a: assert property (key_rd(KEY_STEP2) |-> ##14 key_rd(KEY_STEP3)) else $error("key step three");
	key_four_a: assert property (key_rd(KEY_STEP3) |-> ##14 key_rd(KEY_STEP4)) else $error("key step four");
	key_five_a: assert property (key_rd(KEY_STEP4) |-> ##14 key_rd(KEY_STEP5)) else $error("key step five");
	key_six_a: assert property (key_rd(KEY_STEP5) |-> ##14 (key_rd(KEY_SAVE) or key_rd(KEY_RESTORE)))
		else $error("key step six");
	key_rdonly_a: assert property (!mem_sel_n && mem_oe_n && !byte_lines_oe |-> mem_wr_n) else $error("key wr low");
	key_top_a: assert property (!mem_sel_n && mem_oe_n && mem_wr_n |-> !mem_addr[14]) else $error("key top bit");
	low_supply_a: assert property (!supply_ok [*3] |-> mem_sel_n && mem_wr_n) else $error("strobe at low supply");
	ready_quiet_a: assert property ($rose(cmd_ready) |-> mem_sel_n && mem_wr_n) else $error("strobe at ready");
	save_busy_a: assert property (key_rd(KEY_SAVE) |-> ##[1:16] nv_busy) else $error("no busy on save");
	rest_busy_a: assert property (key_rd(KEY_RESTORE) |-> ##[1:16] nv_busy) else $error("no busy on restore");
endmodule
bind nvss_host nvss_host_props u_nvss_host_props (.*);
`default_nettype wire

// ### nvss_mem_model.sv
// Behavioural memory with shadow cells and key matcher.
// Driven only by the host pins and the supply flag.
`timescale 1ns/1ps
`default_nettype none
module nvss_mem_model
	import nvss_pkg::*;
(
	input wire logic supply_ok,
	input wire logic [14:0] mem_addr,
	input wire logic mem_sel_n,
	input wire logic mem_wr_n,
	input wire logic mem_oe_n,
	input wire logic [7:0] byte_lines_out,
	input wire logic byte_lines_oe,
	output logic [7:0] byte_lines_in
);
	logic [7:0] arr [0:32767];
	logic [7:0] nv [0:32767];
	logic [13:0] keys [0:4] = '{KEY_STEP1, KEY_STEP2, KEY_STEP3, KEY_STEP4, KEY_STEP5};
	logic [7:0] last = 8'h00;
	logic pend = 1'b1;
	logic busy = 1'b0;
	int step = 0;
	int saves = 0;
	int restores = 0;
	// Shadow cells start cleared
	initial foreach (nv[i]) nv[i] = 8'h00;
	// Restore request latch and power-up restore
	always @(negedge supply_ok) pend = 1'b1;
	always @(posedge supply_ok) if (pend) begin
		arr = nv;
		pend = 1'b0;
		busy = 1'b0;
	end
	// Key matcher, sampled once the cycle settles
	always @(negedge mem_sel_n) begin
		#1;
		if (!mem_wr_n) step = 0;
		else if (step == 5 && mem_addr[13:0] == KEY_SAVE && supply_ok) begin
			saves++;
			nv = arr;
			busy = 1'b1;
			step = 0;
		end else if (step == 5 && mem_addr[13:0] == KEY_RESTORE) begin
			restores++;
			foreach (arr[i]) arr[i] = 8'h00;
			arr = nv;
			step = 0;
		end else if (step < 5 && mem_addr[13:0] == keys[step]) step++;
		else step = int'(mem_addr[13:0] == KEY_STEP1);
	end
	// Array writes, blocked at low supply or while saving
	always @* if (!mem_sel_n && !mem_wr_n && byte_lines_oe && supply_ok && !busy) arr[mem_addr] = byte_lines_out;
	// Data line: read drive, host drive, else a stale-inverted value
	always @* begin
		if (!mem_sel_n && !mem_oe_n && mem_wr_n && !busy) byte_lines_in = arr[mem_addr];
		else if (byte_lines_oe) byte_lines_in = byte_lines_out;
		else byte_lines_in = ~last;
	end
	always @(posedge mem_sel_n) last = byte_lines_in;
endmodule
`default_nettype wire

// ### nvss_host_test.sv
// Self-checking bench for nvss_host against the memory model.
// Inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module nvss_host_test;
	import nvss_pkg::*;
	// Supply starts low so the memory latches its power-up restore
	logic ref_clk = 0, rst = 1, supply_ok = 0, cmd_valid = 0;
	logic [1:0] cmd_op = 0;
	logic [14:0] cmd_addr = 0, mem_addr;
	logic [7:0] cmd_wdata = 0, rsp_rdata, byte_lines_out, byte_lines_in;
	logic cmd_ready, rsp_valid, nv_busy, mem_sel_n, mem_wr_n, mem_oe_n, byte_lines_oe;
	int bad_count = 0, n_tests = 0, n;
	always #2 ref_clk = ~ref_clk;
	nvss_host u_nvss_host (.*);
	nvss_mem_model u_nvss_mem_model (.*);
	// Compare and count
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Present one command and hold it until taken
	task issue(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		{cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, op, a, d};
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 0;
	endtask
	// Issue one command, wait for its answer; a run-out limit is a mismatch
	task run(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d, input int lim);
		issue(op, a, d);
		n = 0;
		while (rsp_valid !== 1'b1 && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		check(rsp_valid, 1);
	endtask
	task close_out;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#((PUP_RESTORE_CLKS + 30000) * 4);
		bad_count++;
		close_out;
	end
	// Power-up wait after reset, supply rising with the release
	task t_power;
		check({nv_busy, cmd_ready, mem_sel_n, mem_wr_n}, 4'hB);
		n = 0;
		while (cmd_ready !== 1'b1 && n < PUP_RESTORE_CLKS + 20) begin
			@(negedge ref_clk);
			n++;
		end
		check(n >= PUP_RESTORE_CLKS - 2 && n < PUP_RESTORE_CLKS + 20, 1);
		check(u_nvss_mem_model.pend, 0);
		$display("t_power done");
	endtask
	// Plain write and read, with a write at a key address in between
	task t_rw;
		run(2'h1, 15'h7FFF, 8'hA5, 40);
		check(n, 15);
		run(2'h1, {1'b0, KEY_STEP1}, 8'h3C, 40);
		run(2'h0, 15'h7FFF, 8'h00, 40);
		check({rsp_rdata, 24'(u_nvss_mem_model.saves)}, {8'hA5, 24'h0});
		$display("t_rw done");
	endtask
	// Software restore: key, wait, array reloaded from cleared shadow
	task t_restore;
		run(2'h3, 15'h0, 8'h00, 6 * 14 + SW_RESTORE_CLKS + 20);
		check(n, 6 * 14 + SW_RESTORE_CLKS + 1);
		check(u_nvss_mem_model.restores, 1);
		run(2'h0, 15'h7FFF, 8'h00, 40);
		check(rsp_rdata, 8'h00);
		$display("t_restore done");
	endtask
	// Save started, then cut short by a supply dip with a write pending
	task t_save;
		run(2'h1, 15'h0200, 8'h77, 40);
		issue(2'h2, 15'h0, 8'h00);
		repeat (6 * 14 + 20) @(negedge ref_clk);
		check({nv_busy, cmd_ready, u_nvss_mem_model.nv[15'h0200]}, {2'b10, 8'h77});
		check(u_nvss_mem_model.saves, 1);
		supply_ok = 0;
		{cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, 2'h1, 15'h0200, 8'h11};
		repeat (20) @(negedge ref_clk);
		check({nv_busy, cmd_ready, mem_wr_n, u_nvss_mem_model.pend}, 4'hB);
		check(u_nvss_mem_model.arr[15'h0200], 8'h77);
		$display("t_save done");
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 0;
		supply_ok = 1;
		t_power;
		t_rw;
		t_restore;
		t_save;
		close_out;
	end
endmodule
`default_nettype wire
